// ===== design/wdr_top.sv
// Watchdog reset timer: AXI4-Lite register file, up-counter and match logic.
// Assumes one 50 MHz bus clock; stop request from the timer unit may be asynchronous and is synchronised onto it.
`default_nettype none
module wdr_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        crystal_clock,
  input  wire logic        realtime_clock,
  input  wire logic        timer_stop_req,
  output logic             watchdog_reset_req
);
  logic [15:0] match_value_r;
  logic [7:0]  count_enable_r;
  logic [15:0] up_counter_r;
  logic [15:0] up_counter_nxt;
  logic [15:0] clock_control_r;
  logic [15:0] clock_control_nxt;
  logic        reset_req_r;
  logic        aw_held_r;
  logic [31:0] aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [1:0]  stop_sync_r;

  logic        tick;
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic        ar_take;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_match;
  logic        wr_enable;
  logic        wr_counter;
  logic        wr_control;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic [15:0] lo_mask;
  logic        counting_on;
  wdr_pkg::wdr_ctrl_type ctrl;

  // Write channel: address and data may arrive in either order
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign wr_fire = (aw_held_r || aw_take) && (w_held_r || w_take) && !bvalid_r;

  // Decode on the aligned word
  assign wr_match   = wr_fire && ({wr_addr[31:2], 2'h0} == wdr_pkg::WDR_MATCH_ADDR);
  assign wr_enable  = wr_fire && ({wr_addr[31:2], 2'h0} == wdr_pkg::WDR_ENABLE_ADDR);
  assign wr_counter = wr_fire && ({wr_addr[31:2], 2'h0} == wdr_pkg::WDR_COUNTER_ADDR);
  assign wr_control = wr_fire && ({wr_addr[31:2], 2'h0} == wdr_pkg::WDR_CONTROL_ADDR);
  assign wr_hit     = wr_match || wr_enable || wr_counter || wr_control;
  assign lo_mask    = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Reserved control bits stay zero
  assign clock_control_nxt = wr_control
    ? {10'h000, (wr_data[5:0] & lo_mask[5:0]) | (clock_control_r[5:0] & ~lo_mask[5:0])}
    : clock_control_r;
  assign ctrl = wdr_pkg::wdr_ctrl_type'(clock_control_r[wdr_pkg::WDR_CTRL_BITS-1:0]);

  // Bit 0 runs the counter
  assign counting_on = count_enable_r[wdr_pkg::WDR_RUN_BIT];

  // A software write wins over a tick in the same cycle
  assign up_counter_nxt = wr_counter
    ? ((wr_data[15:0] & lo_mask) | (up_counter_r & ~lo_mask))
    : ((counting_on && tick) ? 16'(up_counter_r + 16'h0001) : up_counter_r);

  wdr_tick_gen u_tick (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .ctrl           (ctrl),
    .crystal_clock  (crystal_clock),
    .realtime_clock (realtime_clock),
    .stop_req       (stop_sync_r[1]),
    .tick           (tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_take && !wr_fire) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (w_take && !wr_fire) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= wdr_pkg::WDR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? wdr_pkg::WDR_RESP_OKAY : wdr_pkg::WDR_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Registers; match value and count reset to fixed values though software must not rely on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_value_r   <= wdr_pkg::WDR_MATCH_RESET;
      count_enable_r  <= wdr_pkg::WDR_ENABLE_RESET;
      up_counter_r    <= wdr_pkg::WDR_COUNTER_RESET;
      clock_control_r <= wdr_pkg::WDR_CONTROL_RESET;
    end else begin
      if (wr_match) begin
        match_value_r <= (wr_data[15:0] & lo_mask) | (match_value_r & ~lo_mask);
      end
      if (wr_enable && wr_strb[0]) begin
        count_enable_r <= {7'h00, wr_data[0]};
      end
      up_counter_r    <= up_counter_nxt;
      clock_control_r <= clock_control_nxt;
    end
  end

  // Timer-unit stop request is synchronised before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_sync_r <= 2'h0;
    end else begin
      stop_sync_r <= {stop_sync_r[0], timer_stop_req};
    end
  end

  // Match raised only while counting, so a stopped, unprogrammed timer stays quiet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_req_r <= 1'b0;
    end else begin
      reset_req_r <= counting_on && (up_counter_r == match_value_r);
    end
  end
  assign watchdog_reset_req = reset_req_r;

  // Read channel
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_r;
  assign rd_hit = ({s_axi_araddr[31:4], 4'h0} == wdr_pkg::WDR_BASE_ADDR);
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr[3:2])
      2'h0: rd_word = {16'h0000, match_value_r};
      2'h1: rd_word = {24'h00_0000, count_enable_r};
      2'h2: rd_word = {16'h0000, up_counter_r};
      2'h3: rd_word = {16'h0000, clock_control_r};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= wdr_pkg::WDR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_hit ? rd_word : 32'h0000_0000;
      rresp_r  <= rd_hit ? wdr_pkg::WDR_RESP_OKAY : wdr_pkg::WDR_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
endmodule
`default_nettype wire

// ===== design/wdr_pkg.sv
// Package for the watchdog reset timer: register map, field layout, reset values.
// Assumes a single 50 MHz bus clock domain and an AXI4-Lite register port.
//
// Function
// - Four registers decoded at 0x10002000 through 0x1000200C.
// - Control register 16 bits, reset zero, bits 15:6 read zero, ignore writes.
// - Divider codes 000..101 divide by 1,4,16,64,256,1024; 110,111 reserved.
// - Control bit 2 crystal, bit 1 real-time, bit 0 bus clock select.
// - Count-enable register 8 bits, reset zero, bits 7:1 read zero.
// - Count-enable bit 0 stops or runs the counter.
// - 16-bit read/write match value, reset value undefined.
// - 16-bit up-counter advancing once per divided tick while enabled.
// - Counter readable and writable at any time; a write sets the count.
// - Counter equal to match value while count-enable bit 0 is set raises the watchdog reset request.
// - Timer-unit stop request gates the count clock and halts counting.
`default_nettype none
package wdr_pkg;
  localparam logic [31:0] WDR_BASE_ADDR     = 32'h1000_2000;
  localparam logic [31:0] WDR_MATCH_ADDR    = 32'h1000_2000;
  localparam logic [31:0] WDR_ENABLE_ADDR   = 32'h1000_2004;
  localparam logic [31:0] WDR_COUNTER_ADDR  = 32'h1000_2008;
  localparam logic [31:0] WDR_CONTROL_ADDR  = 32'h1000_200C;
  localparam int          WDR_DIV_LSB       = 3;
  localparam int          WDR_DIV_MSB       = 5;
  localparam int          WDR_SEL_XTAL_BIT  = 2;
  localparam int          WDR_SEL_RTC_BIT   = 1;
  localparam int          WDR_SEL_BUS_BIT   = 0;
  localparam int          WDR_CTRL_BITS     = 6;
  localparam int          WDR_RUN_BIT       = 0;
  localparam logic [15:0] WDR_CONTROL_RESET = 16'h0000;
  localparam logic [7:0]  WDR_ENABLE_RESET  = 8'h00;
  localparam logic [15:0] WDR_MATCH_RESET   = 16'hFFFF;
  localparam logic [15:0] WDR_COUNTER_RESET = 16'h0000;
  localparam logic [2:0]  WDR_DIV_MAX_CODE  = 3'h5;
  localparam logic [1:0]  WDR_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  WDR_RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [2:0] divider_select;
    logic       crystal_source_sel;
    logic       realtime_source_sel;
    logic       busclock_source_sel;
  } wdr_ctrl_type;
endpackage
`default_nettype wire

// ===== design/wdr_tick_gen.sv
// Count-tick generator: picks a source, prescales it, yields a one-cycle pulse.
// Assumes crystal and real-time clocks arrive as plain asynchronous levels.
`default_nettype none
module wdr_tick_gen (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire wdr_pkg::wdr_ctrl_type ctrl,
  input  wire logic                  crystal_clock,
  input  wire logic                  realtime_clock,
  input  wire logic                  stop_req,
  output logic                       tick
);
  logic [1:0] xtal_sync_r;
  logic [1:0] rtc_sync_r;
  logic       xtal_prev_r;
  logic       rtc_prev_r;
  logic [9:0] presc_r;
  logic [9:0] presc_nxt;
  logic       tick_r;
  logic       src_edge;
  logic       src_ok;
  logic       div_ok;
  logic       div_hit;
  logic [9:0] div_mask;

  // Two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_sync_r <= 2'h0;
      rtc_sync_r  <= 2'h0;
      xtal_prev_r <= 1'b0;
      rtc_prev_r  <= 1'b0;
    end else begin
      xtal_sync_r <= {xtal_sync_r[0], crystal_clock};
      rtc_sync_r  <= {rtc_sync_r[0], realtime_clock};
      xtal_prev_r <= xtal_sync_r[1];
      rtc_prev_r  <= rtc_sync_r[1];
    end
  end

  // Slow sources become rising-edge pulses on the bus clock
  assign src_edge = ctrl.busclock_source_sel
                  | (ctrl.crystal_source_sel & xtal_sync_r[1] & ~xtal_prev_r)
                  | (ctrl.realtime_source_sel & rtc_sync_r[1] & ~rtc_prev_r);
  // With the bus-clock bit set every cycle counts; crystal and real-time bits together count edges of both
  assign src_ok   = ctrl.busclock_source_sel | ctrl.crystal_source_sel
                  | ctrl.realtime_source_sel;
  assign div_ok   = ctrl.divider_select <= wdr_pkg::WDR_DIV_MAX_CODE;
  // Divide by 4^code: mask of the low 2*code prescaler bits
  assign div_mask = 10'(~(10'h3FF << {ctrl.divider_select[2:0], 1'b0}));
  assign div_hit  = (presc_r & div_mask) == div_mask;
  assign presc_nxt = (src_ok && div_ok && !stop_req && src_edge) ? 10'(presc_r + 10'h1)
                                                                  : presc_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 10'h000;
      tick_r  <= 1'b0;
    end else begin
      presc_r <= presc_nxt;
      // Stop request gates the tick
      tick_r  <= src_ok && div_ok && !stop_req && src_edge && div_hit;
    end
  end

  assign tick = tick_r;
endmodule
`default_nettype wire

// ===== testbench/wdr_top_monitor.sv
// Checker for the watchdog reset timer register port.
// Sees only top-level ports; bound into every wdr_top instance.
`default_nettype none
module wdr_top_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  wire logic ar_fire;
  wire logic ar_mapped;
  assign ar_fire   = s_axi_arvalid && s_axi_arready;
  assign ar_mapped = s_axi_araddr[31:4] == 28'h1000200;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted under pending response");
  a_read_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted under pending data");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    ar_fire |=> s_axi_rvalid)
    else $error("read data late");
  a_unmapped_err: assert property (
    ar_fire && !ar_mapped |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (
    ar_fire && ar_mapped |=> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  a_ctrl_reserved: assert property (
    ar_fire && s_axi_araddr == 32'h1000200C |=> s_axi_rdata[31:6] == 26'h0)
    else $error("control reserved bits not zero");
  a_enable_reserved: assert property (
    ar_fire && s_axi_araddr == 32'h10002004 |=> s_axi_rdata[31:1] == 31'h0)
    else $error("enable reserved bits not zero");
endmodule

bind wdr_top wdr_top_monitor u_mon (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready)
);
`default_nettype wire

// ===== testbench/wdr_top_tb.sv
// Self-checking bench for the watchdog reset timer.
// Drives the top module directly; the register master lives in tasks.
`default_nettype none
module wdr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MA = wdr_pkg::WDR_MATCH_ADDR;
  localparam logic [31:0] EA = wdr_pkg::WDR_ENABLE_ADDR;
  localparam logic [31:0] CA = wdr_pkg::WDR_COUNTER_ADDR;
  localparam logic [31:0] KA = wdr_pkg::WDR_CONTROL_ADDR;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        crystal_clock = 1'b0, realtime_clock = 1'b0, timer_stop_req = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        watchdog_reset_req;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  logic [31:0] rd, c1;
  logic [15:0] v;
  integer      n_mismatch = 0, total_checks = 0, seed = 32'h58599ABD, n;

  always #10 aclk = ~aclk;
  wdr_top DUT (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .s_axi_awaddr       (s_axi_awaddr),
    .s_axi_awvalid      (s_axi_awvalid),
    .s_axi_awready      (s_axi_awready),
    .s_axi_wdata        (s_axi_wdata),
    .s_axi_wstrb        (s_axi_wstrb),
    .s_axi_wvalid       (s_axi_wvalid),
    .s_axi_wready       (s_axi_wready),
    .s_axi_bresp        (s_axi_bresp),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_araddr       (s_axi_araddr),
    .s_axi_arvalid      (s_axi_arvalid),
    .s_axi_arready      (s_axi_arready),
    .s_axi_rdata        (s_axi_rdata),
    .s_axi_rresp        (s_axi_rresp),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .crystal_clock      (crystal_clock),
    .realtime_clock     (realtime_clock),
    .timer_stop_req     (timer_stop_req),
    .watchdog_reset_req (watchdog_reset_req)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    // Late bready so the response is seen to stand
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    br = s_axi_bresp;
  endtask

  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  // Bus latency adds a few ticks at divide 1, under one tick above
  function automatic logic div_ok(input int code, input logic [31:0] c);
    if (code > 5) return c === 32'h0;
    return c >= 32'h7 && c <= 32'h10;
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_mismatch++;
    complete_run;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      rdr(KA);
      chk("control reset", 32'h0, rd);
      rdr(EA);
      chk("enable reset", 32'h0, rd);
      wr(KA, 32'hFFFF_FFFF);
      chk("write resp", 32'h0, {30'h0, br});
      rdr(KA);
      chk("control mask", 32'h3F, rd);
      wr(EA, 32'hFF);
      rdr(EA);
      chk("enable mask", 32'h1, rd);
      // Second pass checks a reset in mid-run
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
    end
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      wr(MA, {16'hFFFF, v});
      rdr(MA);
      chk("match", {16'h0, v}, rd);
      wr(CA, {16'hFFFF, ~v});
      rdr(CA);
      chk("counter", {16'h0, ~v}, rd);
    end
    // Upper byte lane only: the low byte must survive
    s_axi_wstrb <= 4'h2;
    wr(MA, 32'h0000_5A00);
    s_axi_wstrb <= 4'hF;
    rdr(MA);
    chk("match byte", {16'h0, 8'h5A, v[7:0]}, rd);
    rdr(32'h1000_2010);
    chk("unmapped resp", 32'h2, {30'h0, rr});
    wr(32'h1000_2010, 32'h0);
    chk("unmapped write", 32'h2, {30'h0, br});
    wr(EA, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wr(KA, {26'h0, k[2:0], 3'h1});
      wr(CA, 32'h0);
      repeat (k > 5 ? 64 : 8 << (2 * k)) @(posedge aclk);
      rdr(CA);
      chk("divided count", 32'h1, {31'h0, div_ok(k, rd)});
    end
    wr(KA, 32'h0);
    wr(CA, 32'h0);
    repeat (32) @(posedge aclk);
    rdr(CA);
    chk("no source", 32'h0, rd);
    wr(KA, 32'h1);
    wr(EA, 32'h0);
    wr(CA, 32'h5);
    repeat (20) @(posedge aclk);
    rdr(CA);
    chk("stopped count", 32'h5, rd);
    wr(EA, 32'h1);
    timer_stop_req <= 1'b1;
    repeat (4) @(posedge aclk);
    rdr(CA);
    c1 = rd;
    repeat (20) @(posedge aclk);
    rdr(CA);
    chk("frozen count", c1, rd);
    timer_stop_req <= 1'b0;
    repeat (4) @(posedge aclk);
    rdr(CA);
    chk("resumed count", 32'h1, {31'h0, rd !== c1});
    // Source edges every 8 bus cycles keep the slow clock legal
    for (int b = 2; b > 0; b--) begin
      wr(KA, 32'h1 << b);
      wr(CA, 32'h0);
      repeat (10) begin
        repeat (4) @(posedge aclk);
        {crystal_clock, realtime_clock} <= (b == 2) ? 2'h2 : 2'h1;
        repeat (4) @(posedge aclk);
        {crystal_clock, realtime_clock} <= 2'h0;
      end
      repeat (4) @(posedge aclk);
      rdr(CA);
      chk("source edges", 32'hA, rd);
    end
    // Divider, match and count, source, then enable
    wr(KA, 32'h0);
    wr(EA, 32'h0);
    wr(MA, 32'h28);
    wr(CA, 32'h0);
    wr(KA, 32'h1);
    chk("idle request", 32'h0, {31'h0, watchdog_reset_req});
    wr(EA, 32'h1);
    n = 0;
    while (watchdog_reset_req !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk("match delay", 32'h1, {31'h0, n >= 36 && n <= 44});
    complete_run;
  end
endmodule
`default_nettype wire
